// ### hdl/rpl_pkg.sv
// constants and types for the volatile profile loader
package rpl_pkg;
	localparam logic [6:0] BUS_ADDR_DEFAULT  = 7'h6a;
	localparam logic [7:0] MODE_REG_ADDR     = 8'h06;
	localparam logic [7:0] MODE_RESET_VALUE  = 8'h00;
	localparam logic [7:0] MODE_READY        = 8'h01;
	localparam logic [7:0] MODE_ACTIVE       = 8'h02;
	localparam logic [7:0] CFG_BASE_ADDR     = 8'h20;
	localparam int         CFG_COUNT         = 11;
	localparam logic [7:0] CFG_RESET_VALUE   = 8'h00;
	localparam int         CFG_REF_MUX       = 0;
	localparam int         CFG_INPUT_DIV     = 1;
	localparam int         CFG_FEEDBACK      = 2;
	localparam int         CFG_INT_DIV0      = 3;
	localparam int         CFG_FRAC_DIV0     = 8;
	localparam logic [7:0] GPIO_ASSIGN_ADDR  = 8'h30;
	localparam logic [7:0] BUS_ADDR_REG_ADDR = 8'h31;
	// straps settle through two flops before the third edge captures them
	localparam logic [1:0] STRAP_WAIT        = 2'h3;
	localparam logic [7:0] UNMAPPED_READ     = 8'h00;
	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b000,
		BUS_ADDR  = 3'b001,
		BUS_AACK  = 3'b010,
		BUS_WDATA = 3'b011,
		BUS_WACK  = 3'b100,
		BUS_RDATA = 3'b101,
		BUS_RACK  = 3'b110
	} rpl_bus_state_type;
endpackage

// ### hdl/rpl_loader.sv
// serial-bus profile loader: staged volatile config, mode register, pins
`timescale 1ns/100ps
module rpl_loader #(
	parameter logic [6:0] DEV_ADDR = rpl_pkg::BUS_ADDR_DEFAULT,
	parameter int         GPIO_N   = 4
) (
	input  wire logic              SYS_CLK,
	input  wire logic              RST,
	input  wire logic              SCL_IN,
	input  wire logic              SDA_IN,
	output logic                   SDA_OUT,
	output logic                   SDA_OE,
	input  wire logic              BLANK_PART,
	input  wire logic [GPIO_N-1:0] GLOBAL_GPIO,
	input  wire logic              REF_PINS_PRESENT,
	input  wire logic [1:0]        REF_SELECT_PINS,
	output logic [GPIO_N-1:0]      GPIO_FUNC_EN,
	output logic                   CLK_RUN,
	output logic [7:0]             OPERATING_STATE,
	output logic [1:0]             REF_SEL,
	output logic [7:0]             INPUT_DIV,
	output logic [7:0]             FEEDBACK_RATIO,
	output logic [7:0]             INT_DIV_0,
	output logic [7:0]             INT_DIV_1,
	output logic [7:0]             INT_DIV_2,
	output logic [7:0]             INT_DIV_3,
	output logic [7:0]             INT_DIV_4,
	output logic [7:0]             FRAC_DIV_0,
	output logic [7:0]             FRAC_DIV_1
);
	import rpl_pkg::*;

	function automatic logic cfg_hit(input logic [7:0] a);
		cfg_hit = (a >= CFG_BASE_ADDR) &&
			(a < CFG_BASE_ADDR + 8'(CFG_COUNT));
	endfunction

	function automatic logic [3:0] cfg_idx(input logic [7:0] a);
		cfg_idx = 4'(a - CFG_BASE_ADDR);
	endfunction

	// pin synchronisers
	logic [1:0] scl_sy_reg, sda_sy_reg;
	logic       scl_d_reg, sda_d_reg;
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			scl_sy_reg <= 2'h3;
			sda_sy_reg <= 2'h3;
			scl_d_reg  <= 1'b1;
			sda_d_reg  <= 1'b1;
		end else begin
			scl_sy_reg <= {scl_sy_reg[0], SCL_IN};
			sda_sy_reg <= {sda_sy_reg[0], SDA_IN};
			scl_d_reg  <= scl_sy_reg[1];
			sda_d_reg  <= sda_sy_reg[1];
		end
	end

	wire scl      = scl_sy_reg[1];
	wire sda      = sda_sy_reg[1];
	wire scl_rise = scl & ~scl_d_reg;
	wire scl_fall = ~scl & scl_d_reg;
	wire bus_start = scl & scl_d_reg & ~sda & sda_d_reg;
	wire bus_stop  = scl & scl_d_reg & sda & ~sda_d_reg;

	// serial bus slave
	rpl_bus_state_type st_reg, st_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next, ptr_reg, ptr_next, rd_data;
	logic       first_reg, first_next, rw_reg, rw_next, oe_reg, oe_next;
	logic       wr_stb;
	logic [7:0] wr_addr, wr_data;

	always_comb begin
		st_next    = st_reg;
		cnt_next   = cnt_reg;
		sh_next    = sh_reg;
		ptr_next   = ptr_reg;
		first_next = first_reg;
		rw_next    = rw_reg;
		oe_next    = oe_reg;
		wr_stb     = 1'b0;
		wr_addr    = ptr_reg;
		wr_data    = sh_reg;
		if (bus_start) begin
			st_next    = BUS_ADDR;
			cnt_next   = 4'h0;
			oe_next    = 1'b0;
			first_next = 1'b1;
		end else if (bus_stop) begin
			st_next = BUS_IDLE;
			oe_next = 1'b0;
		end else if (scl_rise) begin
			if (st_reg == BUS_ADDR || st_reg == BUS_WDATA) begin
				sh_next  = {sh_reg[6:0], sda};
				cnt_next = cnt_reg + 4'h1;
			end else if (st_reg == BUS_RACK && sda) begin
				st_next = BUS_IDLE;
			end
		end else if (scl_fall) begin
			case (st_reg)
				BUS_ADDR: begin
					if (cnt_reg == 4'h8) begin
						cnt_next = 4'h0;
						if (sh_reg[7:1] == DEV_ADDR) begin
							st_next = BUS_AACK;
							oe_next = 1'b1;
							rw_next = sh_reg[0];
						end else begin
							st_next = BUS_IDLE;
						end
					end
				end
				BUS_AACK, BUS_RACK: begin
					if (st_reg == BUS_RACK || rw_reg) begin
						st_next  = BUS_RDATA;
						sh_next  = rd_data;
						oe_next  = ~rd_data[7];
						cnt_next = 4'h1;
						ptr_next = ptr_reg + 8'h01;
					end else begin
						st_next = BUS_WDATA;
						oe_next = 1'b0;
					end
				end
				BUS_WDATA: begin
					if (cnt_reg == 4'h8) begin
						st_next  = BUS_WACK;
						oe_next  = 1'b1;
						cnt_next = 4'h0;
						if (first_reg) begin
							ptr_next   = sh_reg;
							first_next = 1'b0;
						end else begin
							wr_stb   = 1'b1;
							ptr_next = ptr_reg + 8'h01;
						end
					end
				end
				BUS_WACK: begin
					st_next = BUS_WDATA;
					oe_next = 1'b0;
				end
				BUS_RDATA: begin
					if (cnt_reg == 4'h8) begin
						st_next  = BUS_RACK;
						oe_next  = 1'b0;
						cnt_next = 4'h0;
					end else begin
						sh_next  = {sh_reg[6:0], 1'b0};
						oe_next  = ~sh_reg[6];
						cnt_next = cnt_reg + 4'h1;
					end
				end
				default: begin
					st_next = BUS_IDLE;
					oe_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			st_reg    <= BUS_IDLE;
			cnt_reg   <= 4'h0;
			sh_reg    <= 8'h00;
			ptr_reg   <= 8'h00;
			first_reg <= 1'b0;
			rw_reg    <= 1'b0;
			oe_reg    <= 1'b0;
		end else begin
			st_reg    <= st_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			ptr_reg   <= ptr_next;
			first_reg <= first_next;
			rw_reg    <= rw_next;
			oe_reg    <= oe_next;
		end
	end

	// mode, staged and active profile, pin functions
	logic [7:0] mode_reg, mode_next;
	logic [7:0] stage_reg [CFG_COUNT];
	logic [7:0] stage_next [CFG_COUNT];
	logic [7:0] act_reg [CFG_COUNT];
	logic [7:0] act_next [CFG_COUNT];
	logic       run_reg, run_next, pp_reg, pp_next, blank_reg, blank_next;
	logic [1:0] ref_reg, ref_next, rp_s1_reg, rp_s2_reg, strap_cnt_reg;
	logic [1:0] strap_cnt_next;
	logic       pp_s1_reg, pp_s2_reg, bl_s1_reg, bl_s2_reg;
	logic [GPIO_N-1:0] gm_s1_reg, gm_s2_reg, gmask_reg, gmask_next;
	logic [GPIO_N-1:0] gpio_reg, gpio_next;
	logic       go_active, strap_done;

	assign go_active  = wr_stb && wr_addr == MODE_REG_ADDR &&
		wr_data == MODE_ACTIVE && mode_reg == MODE_READY;
	assign strap_done = strap_cnt_reg == STRAP_WAIT;

	always_comb begin
		mode_next      = mode_reg;
		stage_next     = stage_reg;
		act_next       = act_reg;
		run_next       = run_reg;
		blank_next     = blank_reg;
		gmask_next     = gmask_reg;
		strap_cnt_next = strap_cnt_reg;
		pp_next        = pp_reg;
		if (!strap_done) begin
			strap_cnt_next = strap_cnt_reg + 2'h1;
			blank_next     = bl_s2_reg;
			gmask_next     = gm_s2_reg;
			pp_next        = pp_s2_reg;
		end
		// pin assignments and bus address writes fall through unstored
		if (wr_stb && wr_addr == MODE_REG_ADDR) begin
			if (wr_data == MODE_READY) begin
				mode_next = MODE_READY;
			end else if (go_active) begin
				mode_next = MODE_ACTIVE;
				act_next  = stage_reg;
				run_next  = 1'b1;
			end
		end else if (wr_stb && cfg_hit(wr_addr) &&
				mode_reg == MODE_READY) begin
			stage_next[cfg_idx(wr_addr)] = wr_data;
		end
		gpio_next = blank_reg ? '0 : gmask_reg;
		ref_next  = pp_reg ? rp_s2_reg : act_reg[CFG_REF_MUX][1:0];
		if (ptr_reg == MODE_REG_ADDR) begin
			rd_data = mode_reg;
		end else if (cfg_hit(ptr_reg)) begin
			rd_data = stage_reg[cfg_idx(ptr_reg)];
		end else begin
			rd_data = UNMAPPED_READ;
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			mode_reg      <= MODE_RESET_VALUE;
			stage_reg     <= '{default: CFG_RESET_VALUE};
			act_reg       <= '{default: CFG_RESET_VALUE};
			run_reg       <= 1'b0;
			blank_reg     <= 1'b1;
			gmask_reg     <= '0;
			gpio_reg      <= '0;
			ref_reg       <= 2'h0;
			pp_reg        <= 1'b0;
			strap_cnt_reg <= 2'h0;
			rp_s1_reg     <= 2'h0;
			rp_s2_reg     <= 2'h0;
			pp_s1_reg     <= 1'b0;
			pp_s2_reg     <= 1'b0;
			bl_s1_reg     <= 1'b1;
			bl_s2_reg     <= 1'b1;
			gm_s1_reg     <= '0;
			gm_s2_reg     <= '0;
		end else begin
			mode_reg      <= mode_next;
			stage_reg     <= stage_next;
			act_reg       <= act_next;
			run_reg       <= run_next;
			blank_reg     <= blank_next;
			gmask_reg     <= gmask_next;
			gpio_reg      <= gpio_next;
			ref_reg       <= ref_next;
			pp_reg        <= pp_next;
			strap_cnt_reg <= strap_cnt_next;
			rp_s1_reg     <= REF_SELECT_PINS;
			rp_s2_reg     <= rp_s1_reg;
			pp_s1_reg     <= REF_PINS_PRESENT;
			pp_s2_reg     <= pp_s1_reg;
			bl_s1_reg     <= BLANK_PART;
			bl_s2_reg     <= bl_s1_reg;
			gm_s1_reg     <= GLOBAL_GPIO;
			gm_s2_reg     <= gm_s1_reg;
		end
	end

	// open drain: only ever pulls low
	assign SDA_OUT         = 1'b0;
	assign SDA_OE          = oe_reg;
	assign GPIO_FUNC_EN    = gpio_reg;
	assign CLK_RUN         = run_reg;
	assign OPERATING_STATE = mode_reg;
	assign REF_SEL         = ref_reg;
	assign INPUT_DIV       = act_reg[CFG_INPUT_DIV];
	assign FEEDBACK_RATIO  = act_reg[CFG_FEEDBACK];
	assign INT_DIV_0       = act_reg[CFG_INT_DIV0];
	assign INT_DIV_1       = act_reg[CFG_INT_DIV0+1];
	assign INT_DIV_2       = act_reg[CFG_INT_DIV0+2];
	assign INT_DIV_3       = act_reg[CFG_INT_DIV0+3];
	assign INT_DIV_4       = act_reg[CFG_INT_DIV0+4];
	assign FRAC_DIV_0      = act_reg[CFG_FRAC_DIV0];
	assign FRAC_DIV_1      = act_reg[CFG_FRAC_DIV0+1];

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	sequence s_ready_write;
		wr_stb && wr_addr == MODE_REG_ADDR && wr_data == MODE_READY;
	endsequence
	sequence s_active_write;
		go_active;
	endsequence
	property p_pins_fixed;
		strap_done && $past(strap_done) |=> $stable(GPIO_FUNC_EN);
	endproperty
	a_pins_fixed: assert property (p_pins_fixed)
		else $error("pin functions changed after strap");
	property p_blank_dead;
		strap_done && blank_reg |=> GPIO_FUNC_EN == '0;
	endproperty
	a_blank_dead: assert property (p_blank_dead)
		else $error("blank part has live pins");
	property p_global_kept;
		strap_done && !blank_reg |=> GPIO_FUNC_EN == gmask_reg;
	endproperty
	a_global_kept: assert property (p_global_kept)
		else $error("global pins lost");
	property p_run_on_active;
		s_active_write |=> CLK_RUN && OPERATING_STATE == MODE_ACTIVE;
	endproperty
	a_run_on_active: assert property (p_run_on_active)
		else $error("clocks not started by active write");
	property p_no_early_run;
		$rose(CLK_RUN) |-> $past(go_active);
	endproperty
	a_no_early_run: assert property (p_no_early_run)
		else $error("clocks started without active write");
	property p_staged_only;
		mode_reg == MODE_READY && !go_active |=> $stable(INPUT_DIV);
	endproperty
	a_staged_only: assert property (p_staged_only)
		else $error("ready write reached active profile");
	property p_ref_choice;
		##1 REF_SEL == ($past(pp_reg) ? $past(rp_s2_reg)
			: $past(act_reg[CFG_REF_MUX][1:0]));
	endproperty
	a_ref_choice: assert property (p_ref_choice)
		else $error("reference select wrong");
	property p_ready_enter;
		s_ready_write |=> OPERATING_STATE == MODE_READY;
	endproperty
	a_ready_enter: assert property (p_ready_enter)
		else $error("ready write not taken");
	property p_ready_then_active;
		s_active_write
			|=> FRAC_DIV_1 == $past(stage_reg[CFG_FRAC_DIV0+1]) &&
			FRAC_DIV_0 == $past(stage_reg[CFG_FRAC_DIV0]);
	endproperty
	a_ready_then_active: assert property (p_ready_then_active)
		else $error("staged divider not applied");
	property p_idle_stage;
		wr_stb && cfg_hit(wr_addr) && mode_reg != MODE_READY
			|=> stage_reg[0] == $past(stage_reg[0]) &&
			stage_reg[1] == $past(stage_reg[1]);
	endproperty
	a_idle_stage: assert property (p_idle_stage)
		else $error("config stored outside ready");
endmodule

// ### sim/rpl_host_model.sv
// host model: serial bus master loading mode and config registers
`timescale 1ns/100ps
module rpl_host_model (
	input  wire logic SYS_CLK,
	input  wire logic SDA_OE,
	output logic      SCL_IN,
	output logic      SDA_IN
);
	import rpl_pkg::*;
	logic pull_low;
	int   nacks;
	// open-drain line with pull-up: low while either side pulls
	assign SDA_IN = !(pull_low || SDA_OE);
	initial begin
		SCL_IN = 1'b1;
		pull_low = 1'b0;
		nacks = 0;
	end
	task half;
		repeat (8) @(posedge SYS_CLK);
		#1;
	endtask
	// data moves mid-low so it never races the clock fall
	task bit_cycle(input logic drv_low, output logic b);
		half;
		pull_low = drv_low;
		half;
		SCL_IN = 1'b1;
		half;
		b = SDA_IN;
		SCL_IN = 1'b0;
	endtask
	task start;
		half;
		pull_low = 1'b0;
		half;
		SCL_IN = 1'b1;
		half;
		pull_low = 1'b1;
		half;
		SCL_IN = 1'b0;
	endtask
	task stop;
		half;
		pull_low = 1'b1;
		half;
		SCL_IN = 1'b1;
		half;
		pull_low = 1'b0;
		half;
	endtask
	task send_byte(input logic [7:0] d);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_cycle(!d[i], a);
		bit_cycle(1'b0, a);
		if (a)
			nacks++;
	endtask
	// one pair per transfer of a single-profile list
	task write_reg(input logic [7:0] ptr, input logic [7:0] d);
		if (ptr === BUS_ADDR_REG_ADDR)
			return;
		start;
		send_byte({BUS_ADDR_DEFAULT, 1'b0});
		send_byte(ptr);
		send_byte(d);
		stop;
	endtask
	task read_reg(input logic [7:0] ptr, output logic [7:0] d);
		logic a;
		start;
		send_byte({BUS_ADDR_DEFAULT, 1'b0});
		send_byte(ptr);
		start;
		send_byte({BUS_ADDR_DEFAULT, 1'b1});
		for (int i = 7; i >= 0; i--)
			bit_cycle(1'b0, d[i]);
		// release for not-acknowledge so the slave lets go before stop
		bit_cycle(1'b0, a);
		stop;
	endtask
endmodule

// ### sim/ram_profile_download_loader_tb_top.sv
// bench: profile load, staging, pin straps and reference choice
`timescale 1ns/100ps
module ram_profile_download_loader_tb_top;
	import rpl_pkg::*;
	logic       sys_clk = 1'b0;
	logic       rst = 1'b1;
	logic       blank = 1'b0;
	logic [3:0] gpio_g = 4'ha;
	logic       pins_on = 1'b0;
	logic [1:0] pins = 2'h1;
	logic       scl;
	logic       sda;
	logic       sda_oe;
	logic       clk_run;
	logic [3:0] gpio_en;
	logic [7:0] op_state;
	logic [1:0] ref_sel;
	logic [7:0] dv [0:8];
	int         fails = 0;
	int         comparisons = 0;
	// 25 MHz in, P 1, ratio 100: 25 MHz ref, 2.5 GHz vco
	logic [7:0] cfg [0:10] = '{8'h02, 8'h01, 8'h64, 8'h0a, 8'h0b,
		8'h0c, 8'h0d, 8'h0e, 8'h14, 8'h15, 8'h00};
	always #2.5 sys_clk = ~sys_clk;
	rpl_loader u_rpl_loader (
		.SYS_CLK(sys_clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda),
		.SDA_OUT(), .SDA_OE(sda_oe), .BLANK_PART(blank),
		.GLOBAL_GPIO(gpio_g), .REF_PINS_PRESENT(pins_on),
		.REF_SELECT_PINS(pins), .GPIO_FUNC_EN(gpio_en),
		.CLK_RUN(clk_run), .OPERATING_STATE(op_state), .REF_SEL(ref_sel),
		.INPUT_DIV(dv[0]), .FEEDBACK_RATIO(dv[1]), .INT_DIV_0(dv[2]),
		.INT_DIV_1(dv[3]), .INT_DIV_2(dv[4]), .INT_DIV_3(dv[5]),
		.INT_DIV_4(dv[6]), .FRAC_DIV_0(dv[7]), .FRAC_DIV_1(dv[8]));
	rpl_host_model u_rpl_host_model (
		.SYS_CLK(sys_clk), .SDA_OE(sda_oe), .SCL_IN(scl), .SDA_IN(sda));
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task tally_and_finish;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task do_reset(input logic b, input logic p);
		@(posedge sys_clk);
		#1;
		rst = 1'b1;
		blank = b;
		pins_on = p;
		repeat (16) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
	endtask
	task t_power_up;
		chk("clk_run", 8'h00, {7'h0, clk_run});
		chk("op_state", MODE_RESET_VALUE, op_state);
		chk("gpio_en", blank ? 8'h00 : {4'h0, gpio_g}, {4'h0, gpio_en});
	endtask
	// config and active writes before ready must leave everything idle
	task t_refused_early;
		logic [7:0] r;
		u_rpl_host_model.write_reg(CFG_BASE_ADDR + 8'h01, 8'h55);
		u_rpl_host_model.write_reg(MODE_REG_ADDR, MODE_ACTIVE);
		chk("clk_run", 8'h00, {7'h0, clk_run});
		u_rpl_host_model.read_reg(CFG_BASE_ADDR + 8'h01, r);
		chk("staged", CFG_RESET_VALUE, r);
	endtask
	task t_load;
		logic [7:0] r;
		logic [1:0] rs;
		u_rpl_host_model.write_reg(MODE_REG_ADDR, MODE_READY);
		u_rpl_host_model.read_reg(MODE_REG_ADDR, r);
		chk("mode", MODE_READY, r);
		for (int i = 0; i < CFG_COUNT; i++)
			u_rpl_host_model.write_reg(CFG_BASE_ADDR + 8'(i), cfg[i]);
		u_rpl_host_model.write_reg(GPIO_ASSIGN_ADDR, {4'h0, ~gpio_g});
		u_rpl_host_model.read_reg(GPIO_ASSIGN_ADDR, r);
		chk("pin_assign", UNMAPPED_READ, r);
		chk("clk_run", 8'h00, {7'h0, clk_run});
		chk("int_div_0", 8'h00, dv[2]);
		u_rpl_host_model.write_reg(MODE_REG_ADDR, MODE_ACTIVE);
		chk("clk_run", 8'h01, {7'h0, clk_run});
		chk("op_state", MODE_ACTIVE, op_state);
		for (int i = 0; i < 9; i++)
			chk("divider", cfg[i + 1], dv[i]);
		rs = pins_on ? pins : cfg[0][1:0];
		chk("ref_sel", {6'h0, rs}, {6'h0, ref_sel});
		chk("gpio_en", blank ? 8'h00 : {4'h0, gpio_g}, {4'h0, gpio_en});
		chk("nacks", 8'h00, u_rpl_host_model.nacks[7:0]);
	endtask
	initial begin
		do_reset(1'b0, 1'b0);
		t_power_up;
		t_refused_early;
		t_load;
		do_reset(1'b1, 1'b1);
		t_power_up;
		t_load;
		tally_and_finish;
	end
	initial begin
		repeat (70000) @(posedge sys_clk);
		fails++;
		tally_and_finish;
	end
endmodule
